//--- src/dlct_regs.svh
// register offsets, field positions, reset values and divider counts of the dual counter/timer
`ifndef DLCT_REGS_SVH
`define DLCT_REGS_SVH

`define DLCT_OFF_CLKCFG   8'h00
`define DLCT_OFF_RUNSTAT  8'h04
`define DLCT_OFF_MODECFG  8'h08
`define DLCT_OFF_T0LO     8'h0c
`define DLCT_OFF_T1LO     8'h10
`define DLCT_OFF_T0HI     8'h14
`define DLCT_OFF_T1HI     8'h18
`define DLCT_OFF_IRQCFG   8'h1c

`define DLCT_RST_BYTE     8'h00
`define DLCT_RST_IRQCFG   4'h0

// timer_clock_config fields
`define DLCT_CK_T3HI      7
`define DLCT_CK_T3LO      6
`define DLCT_CK_T2HI      5
`define DLCT_CK_T2LO      4
`define DLCT_CK_T1SEL     3
`define DLCT_CK_T0SEL     2
`define DLCT_CK_PRE_HI    1
`define DLCT_CK_PRE_LO    0

// timer_run_status fields
`define DLCT_RS_TF1       7
`define DLCT_RS_TR1       6
`define DLCT_RS_TF0       5
`define DLCT_RS_TR0       4

// timer_mode_config fields
`define DLCT_MD_GATE1     7
`define DLCT_MD_CT1       6
`define DLCT_MD_M1_HI     5
`define DLCT_MD_M1_LO     4
`define DLCT_MD_FIRST_GATE_ENABLE     3
`define DLCT_MD_CT0       2
`define DLCT_MD_M0_HI     1
`define DLCT_MD_M0_LO     0

// interrupt enable / input polarity fields
`define DLCT_IC_ET0       0
`define DLCT_IC_ET1       1
`define DLCT_IC_POLA      2
`define DLCT_IC_POLB      3

// prescaler terminal counts (divide minus one)
`define DLCT_DIV12_LAST   6'd11
`define DLCT_DIV4_LAST    6'd3
`define DLCT_DIV48_LAST   6'd47
`define DLCT_DIV8_LAST    3'd7

`define DLCT_ALL_ONES8    8'hff

`endif

//--- src/dlct_pkg.sv
// types shared by the dual counter/timer
`default_nettype none
package dlct_pkg;

  typedef enum logic [1:0] {
    DLCT_MODE13  = 2'b00,
    DLCT_MODE16  = 2'b01,
    DLCT_MODE8AR = 2'b10,
    DLCT_SPLIT   = 2'b11
  } dlct_mode_t;

  typedef enum logic [1:0] {
    DLCT_PRE12  = 2'b00,
    DLCT_PRE4   = 2'b01,
    DLCT_PRE48  = 2'b10,
    DLCT_PREEXT = 2'b11
  } dlct_pre_t;

  typedef struct packed {
    logic [7:0]  clkCfg;
    logic [7:0]  runStat;
    logic [7:0]  modeCfg;
    logic [7:0]  t0Lo;
    logic [7:0]  t0Hi;
    logic [7:0]  t1Lo;
    logic [7:0]  t1Hi;
    logic [3:0]  irqCfg;
    logic        ack;
    logic [31:0] rdata;
    logic [5:0]  preCnt;
    logic [2:0]  extDiv;
    logic        extSync1;
    logic        extSync2;
    logic        extPrev;
    logic        pinAPrev;
    logic        pinBPrev;
    logic        t1OvfPulse;
  } dlct_state_t;

endpackage : dlct_pkg
`default_nettype wire

//--- src/dlct_timer.sv
// dual counter/timer with shared prescaler behind a classic wishbone slave
// What this block does
// - third timer high-byte select 1 picks system clock, else its own source; split only
// - first timer select: 1 system clock, 0 prescaled; ignored when counting pin events
// - prescale field: /12, /4, /48, or external clock /8 synchronised
// - each timer holds a 16-bit count read and written as low and high bytes
// - 13-bit mode: high byte upper eight bits, low byte bits 4..0 lower five
// - 13-bit wrap from all ones sets overflow flag and interrupt if enabled
// - counter select 1 counts pin falling edges, 0 uses the selected clock
// - outside split mode, counts only while run is 1 and gate is 0 or external input active
// - setting run does not clear the count
// - second timer gated by second external input with its own polarity
// - mode 1 uses the full 16-bit count, wrapping all ones to zero
// - mode 2 low byte counts, reloads from unchanged high byte on wrap, sets flag
// - first timer mode 3 low byte uses first timer run, select, gate and flag
// - mode 3 high byte counts clock only, runs on second run bit, sets second flag
// - during split, second timer ignores pins, never sets its flag, still pulses overflow
// - during split, second timer runs in modes 0-2 and halts in mode 3
// - each overflow interrupt forwarded only when its enable bit is set
// - each timer takes its mode from its own two mode bits
// - overflow flags writable by software, cleared by hardware on interrupt vector
//
// Our own choices: the register offsets and the Wishbone register port.
`default_nettype none
`include "dlct_regs.svh"

module dlct_timer
  import dlct_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        we_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        first_count_pin,
  input  wire logic        second_count_pin,
  input  wire logic        ext_irq_input_a,
  input  wire logic        ext_irq_input_b,
  input  wire logic        extClk,
  input  wire logic        firstVectorTaken,
  input  wire logic        secondVectorTaken,
  output logic             firstTimerIrq,
  output logic             secondTimerIrq,
  output logic             secondTimerOvf,
  output logic             third_timer_hi_clk_sel,
  output logic             third_timer_lo_clk_sel,
  output logic             fourthTimerHiClkSel,
  output logic             fourthTimerLoClkSel
);

  dlct_state_t st;
  dlct_state_t next_st;

  // one step of a timer in modes 0..2; returns {overflow, high, low}
  function automatic logic [16:0] dlct_step(input dlct_mode_t m, input logic [7:0] lo,
                                            input logic [7:0] hi);
    logic [13:0] c13;
    logic [16:0] c16;
    logic [16:0] res;
    c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    c16 = {1'b0, hi, lo} + 17'h00001;
    res = {1'b0, hi, lo};
    unique case (m)
      DLCT_MODE13: begin
        // upper three low-byte bits are left as they are
        res = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
      end
      DLCT_MODE16: begin
        res = c16;
      end
      DLCT_MODE8AR: begin
        if (lo == `DLCT_ALL_ONES8) begin
          res = {1'b1, hi, hi};
        end else begin
          res = {1'b0, hi, lo + 8'h01};
        end
      end
      DLCT_SPLIT: begin
        res = {1'b0, hi, lo};
      end
    endcase
    return res;
  endfunction : dlct_step

  logic       req;
  logic       wrLane;
  logic       preTick;
  logic       extRise;
  logic [1:0] pinNow;
  logic [1:0] pinLast;
  logic [1:0] gateIn;
  logic [1:0] gatePol;
  logic [1:0] gateOn;
  logic [1:0] pinFall;
  logic [1:0] gateOk;
  logic       t0Clk;
  logic       t1Clk;
  logic       t0Tick;
  logic       t1Tick;
  logic       t0HiTick;
  logic       split;
  logic [16:0] t0Res;
  logic [16:0] t1Res;
  logic       t0Ovf;
  logic       t1Ovf;
  logic       t0HiOvf;
  logic [5:0] preLast;
  dlct_mode_t m0;
  dlct_mode_t m1;
  dlct_pre_t  pre;

  // both timers condition their pin and gate inputs the same way
  assign pinNow  = {second_count_pin, first_count_pin};
  assign pinLast = {st.pinBPrev, st.pinAPrev};
  assign gateIn  = {ext_irq_input_b, ext_irq_input_a};
  assign gatePol = {st.irqCfg[`DLCT_IC_POLB], st.irqCfg[`DLCT_IC_POLA]};
  assign gateOn  = {st.modeCfg[`DLCT_MD_GATE1], st.modeCfg[`DLCT_MD_FIRST_GATE_ENABLE]};

  for (genvar g = 0; g < 2; g++) begin : g_tmr_in
    assign pinFall[g] = pinLast[g] & ~pinNow[g];
    assign gateOk[g]  = ~gateOn[g] | (gateIn[g] == gatePol[g]);
  end

  always_comb begin
    next_st = st;
    req     = cyc_i & stb_i & ~st.ack;
    wrLane  = req & we_i & sel_i[0];
    m0      = dlct_mode_t'(st.modeCfg[`DLCT_MD_M0_HI:`DLCT_MD_M0_LO]);
    m1      = dlct_mode_t'(st.modeCfg[`DLCT_MD_M1_HI:`DLCT_MD_M1_LO]);
    pre     = dlct_pre_t'(st.clkCfg[`DLCT_CK_PRE_HI:`DLCT_CK_PRE_LO]);
    split   = (m0 == DLCT_SPLIT);

    // shared prescaler
    next_st.extSync1 = extClk;
    next_st.extSync2 = st.extSync1;
    next_st.extPrev  = st.extSync2;
    extRise = st.extSync2 & ~st.extPrev;
    unique case (pre)
      DLCT_PRE12:  preLast = `DLCT_DIV12_LAST;
      DLCT_PRE4:   preLast = `DLCT_DIV4_LAST;
      DLCT_PRE48:  preLast = `DLCT_DIV48_LAST;
      DLCT_PREEXT: preLast = `DLCT_DIV12_LAST;
    endcase
    if (pre == DLCT_PREEXT) begin
      // external clock only reaches the timers after synchronising
      preTick = extRise & (st.extDiv == `DLCT_DIV8_LAST);
      next_st.preCnt = 6'd0;
      if (extRise) begin
        next_st.extDiv = st.extDiv + 3'd1;
      end
    end else begin
      preTick = (st.preCnt >= preLast);
      next_st.preCnt = preTick ? 6'd0 : st.preCnt + 6'd1;
      next_st.extDiv = 3'd0;
    end

    // pins are sampled once per clock; fast pulses are missed
    next_st.pinAPrev = first_count_pin;
    next_st.pinBPrev = second_count_pin;

    t0Clk = st.clkCfg[`DLCT_CK_T0SEL] ? 1'b1 : preTick;
    t1Clk = st.clkCfg[`DLCT_CK_T1SEL] ? 1'b1 : preTick;

    t0Tick = (st.modeCfg[`DLCT_MD_CT0] ? pinFall[0] : t0Clk) &
             st.runStat[`DLCT_RS_TR0] & gateOk[0];
    if (split) begin
      // timer 1 run follows its mode alone while timer 0 is split
      t1Tick = t1Clk & (m1 != DLCT_SPLIT);
    end else begin
      t1Tick = (st.modeCfg[`DLCT_MD_CT1] ? pinFall[1] : t1Clk) &
               st.runStat[`DLCT_RS_TR1] & gateOk[1];
    end
    t0HiTick = split & t0Clk & st.runStat[`DLCT_RS_TR1];

    // count updates; run bit never clears the count
    t0Res   = dlct_step(m0, st.t0Lo, st.t0Hi);
    t1Res   = dlct_step(m1, st.t1Lo, st.t1Hi);
    t0Ovf   = 1'b0;
    t0HiOvf = 1'b0;
    t1Ovf   = 1'b0;
    if (split) begin
      if (t0Tick) begin
        next_st.t0Lo = st.t0Lo + 8'h01;
        t0Ovf = (st.t0Lo == `DLCT_ALL_ONES8);
      end
      if (t0HiTick) begin
        next_st.t0Hi = st.t0Hi + 8'h01;
        t0HiOvf = (st.t0Hi == `DLCT_ALL_ONES8);
      end
    end else if (t0Tick) begin
      next_st.t0Lo = t0Res[7:0];
      next_st.t0Hi = t0Res[15:8];
      t0Ovf = t0Res[16];
    end
    if (t1Tick) begin
      next_st.t1Lo = t1Res[7:0];
      next_st.t1Hi = t1Res[15:8];
      t1Ovf = t1Res[16];
    end
    next_st.t1OvfPulse = t1Ovf;

    // software writes of bytes and registers
    if (wrLane) begin
      unique case (adr_i)
        `DLCT_OFF_CLKCFG:  next_st.clkCfg  = dat_i[7:0];
        `DLCT_OFF_RUNSTAT: next_st.runStat = dat_i[7:0];
        `DLCT_OFF_MODECFG: next_st.modeCfg = dat_i[7:0];
        `DLCT_OFF_T0LO:    next_st.t0Lo    = dat_i[7:0];
        `DLCT_OFF_T0HI:    next_st.t0Hi    = dat_i[7:0];
        `DLCT_OFF_T1LO:    next_st.t1Lo    = dat_i[7:0];
        `DLCT_OFF_T1HI:    next_st.t1Hi    = dat_i[7:0];
        `DLCT_OFF_IRQCFG:  next_st.irqCfg  = dat_i[3:0];
        default: ;
      endcase
    end
    // vector clears, then hardware set wins over any clear
    if (firstVectorTaken) begin
      next_st.runStat[`DLCT_RS_TF0] = 1'b0;
    end
    if (secondVectorTaken) begin
      next_st.runStat[`DLCT_RS_TF1] = 1'b0;
    end
    if (t0Ovf) begin
      next_st.runStat[`DLCT_RS_TF0] = 1'b1;
    end
    if (t0HiOvf | (t1Ovf & ~split)) begin
      next_st.runStat[`DLCT_RS_TF1] = 1'b1;
    end

    // read data captured with the acknowledge
    next_st.ack = req;
    if (req & ~we_i) begin
      unique case (adr_i)
        `DLCT_OFF_CLKCFG:  next_st.rdata = {24'h000000, st.clkCfg};
        `DLCT_OFF_RUNSTAT: next_st.rdata = {24'h000000, st.runStat};
        `DLCT_OFF_MODECFG: next_st.rdata = {24'h000000, st.modeCfg};
        `DLCT_OFF_T0LO:    next_st.rdata = {24'h000000, st.t0Lo};
        `DLCT_OFF_T0HI:    next_st.rdata = {24'h000000, st.t0Hi};
        `DLCT_OFF_T1LO:    next_st.rdata = {24'h000000, st.t1Lo};
        `DLCT_OFF_T1HI:    next_st.rdata = {24'h000000, st.t1Hi};
        `DLCT_OFF_IRQCFG:  next_st.rdata = {28'h0000000, st.irqCfg};
        default:           next_st.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st.ack        <= '0;
      st.rdata      <= '0;
      st.preCnt     <= '0;
      st.extDiv     <= '0;
      st.extSync1   <= '0;
      st.extSync2   <= '0;
      st.extPrev    <= '0;
      st.pinAPrev   <= '0;
      st.pinBPrev   <= '0;
      st.t1OvfPulse <= '0;
      st.clkCfg     <= `DLCT_RST_BYTE;
      st.runStat    <= `DLCT_RST_BYTE;
      st.modeCfg    <= `DLCT_RST_BYTE;
      st.t0Lo       <= `DLCT_RST_BYTE;
      st.t0Hi       <= `DLCT_RST_BYTE;
      st.t1Lo       <= `DLCT_RST_BYTE;
      st.t1Hi       <= `DLCT_RST_BYTE;
      st.irqCfg     <= `DLCT_RST_IRQCFG;
    end else begin
      st <= next_st;
    end
  end

  assign dat_o          = st.rdata;
  assign ack_o          = st.ack;
  assign firstTimerIrq  = st.runStat[`DLCT_RS_TF0] & st.irqCfg[`DLCT_IC_ET0];
  assign secondTimerIrq = st.runStat[`DLCT_RS_TF1] & st.irqCfg[`DLCT_IC_ET1];
  assign secondTimerOvf = st.t1OvfPulse;
  // the third and fourth timers live elsewhere; only their selects leave here
  assign third_timer_hi_clk_sel = st.clkCfg[`DLCT_CK_T2HI];
  assign third_timer_lo_clk_sel = st.clkCfg[`DLCT_CK_T2LO];
  assign fourthTimerHiClkSel    = st.clkCfg[`DLCT_CK_T3HI];
  assign fourthTimerLoClkSel    = st.clkCfg[`DLCT_CK_T3LO];

endmodule : dlct_timer
`default_nettype wire

//--- tb/dlct_timer_assertions.sv
// concurrent checks on the bus and status ports of the dual counter/timer
`default_nettype none
module dlct_timer_checker (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  input wire logic        firstVectorTaken,
  input wire logic        secondVectorTaken,
  input wire logic        firstTimerIrq,
  input wire logic        secondTimerIrq,
  input wire logic        third_timer_hi_clk_sel,
  input wire logic        third_timer_lo_clk_sel,
  input wire logic        fourthTimerHiClkSel,
  input wire logic        fourthTimerLoClkSel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic take;
  assign take = cyc_i && stb_i && !ack_o;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  chk_ack_answer: assert property (take |=> ack_o)
    else $error("request not answered");
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  chk_ack_cause: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");
  chk_read_upper: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_read_hold: assert property ($changed(dat_o) |-> $past(take && !we_i))
    else $error("read data moved without a read");
  chk_sel_write: assert property ($changed({third_timer_hi_clk_sel, third_timer_lo_clk_sel,
    fourthTimerHiClkSel, fourthTimerLoClkSel}) |-> $past(take && we_i))
    else $error("clock select moved without a write");
  chk_first_clear: assert property ($fell(firstTimerIrq) |->
    $past(firstVectorTaken || (take && we_i)))
    else $error("first interrupt dropped on its own");
  chk_second_clear: assert property ($fell(secondTimerIrq) |->
    $past(secondVectorTaken || (take && we_i)))
    else $error("second interrupt dropped on its own");
  cover property (take && we_i);
  cover property (take && !we_i);
  cover property ($rose(secondTimerIrq));
  cover property ($fell(firstTimerIrq));
endmodule : dlct_timer_checker

bind dlct_timer dlct_timer_checker u_chk (.clk, .arst_n, .cyc_i, .stb_i, .we_i, .ack_o, .dat_o,
  .firstVectorTaken, .secondVectorTaken, .firstTimerIrq, .secondTimerIrq,
  .third_timer_hi_clk_sel, .third_timer_lo_clk_sel, .fourthTimerHiClkSel, .fourthTimerLoClkSel);
`default_nettype wire

//--- tb/dlct_pins.sv
// outside-world model of the two count pins
`default_nettype none
module dlct_pins (
  input  wire logic clk,
  output logic      pinA,
  output logic      pinB
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pinA = 1'b1;
    pinB = 1'b1;
  end
  // three clocks per level, safely above the one-clock sampling minimum
  task automatic pulse(input int n, input logic onB);
    repeat (n) begin
      @(posedge clk);
      {pinB, pinA} <= onB ? 2'b01 : 2'b10;
      repeat (3) @(posedge clk);
      {pinB, pinA} <= 2'b11;
      repeat (3) @(posedge clk);
    end
  endtask : pulse
endmodule : dlct_pins
`default_nettype wire

//--- tb/dlct_timer_tb.sv
// self-checking bench for the dual counter/timer
`default_nettype none
`include "dlct_regs.svh"
module dlct_timer_tb import dlct_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, arst_n, we_i, cyc_i, stb_i, extClk, ext_irq_input_a, ext_irq_input_b;
  logic        firstVectorTaken, secondVectorTaken, ack_o, first_count_pin, second_count_pin;
  logic        firstTimerIrq, secondTimerIrq, secondTimerOvf, third_timer_hi_clk_sel;
  logic        third_timer_lo_clk_sel, fourthTimerHiClkSel, fourthTimerLoClkSel;
  logic [7:0]  adr_i, q;
  logic [31:0] dat_i, dat_o;
  logic [3:0]  sel_i, sels;
  int          n_errors, check_count;
  logic [7:0]  lo [3] = '{8'h1f, 8'hff, 8'hfe};
  logic [7:0]  hi [3] = '{8'hff, 8'hff, 8'hc0};
  logic [7:0]  ex [3] = '{8'h00, 8'h00, 8'hc0};
  logic [7:0]  pe [4] = '{8'd8, 8'd24, 8'd2, 8'd6};
  assign sels = {third_timer_hi_clk_sel, third_timer_lo_clk_sel, fourthTimerHiClkSel,
    fourthTimerLoClkSel};

  dlct_timer u_dut (.clk, .arst_n, .adr_i, .dat_i, .sel_i, .we_i, .cyc_i, .stb_i, .dat_o,
    .ack_o, .first_count_pin, .second_count_pin, .ext_irq_input_a, .ext_irq_input_b, .extClk,
    .firstVectorTaken, .secondVectorTaken, .firstTimerIrq, .secondTimerIrq, .secondTimerOvf,
    .third_timer_hi_clk_sel, .third_timer_lo_clk_sel, .fourthTimerHiClkSel, .fourthTimerLoClkSel);
  dlct_pins u_pins (.clk, .pinA(first_count_pin), .pinB(second_count_pin));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // external prescale clock runs free; only the external prescale setting uses it
  initial begin
    extClk = 1'b0;
    forever @(posedge clk) extClk <= ~extClk;
  end

  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    adr_i <= a;
    we_i <= w;
    dat_i <= {24'h0, d};
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do @(posedge clk); while (ack_o !== 1'b1);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    chk(q, e);
  endtask : rc
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  // roughly twelve hundred cycles of tests; generous margin for a hang
  initial begin
    #60000;
    n_errors++;
    close_out();
  end

  initial begin
    {arst_n, cyc_i, stb_i, we_i, firstVectorTaken, secondVectorTaken} = '0;
    {ext_irq_input_a, ext_irq_input_b} = 2'b01;
    adr_i = 8'h00;
    dat_i = '0;
    sel_i = 4'hf;
    n_errors = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) rc(8'(i * 4), 8'h00);
    wr(8'h20, 8'hff);
    rc(8'h20, 8'h00);
    wr(`DLCT_OFF_CLKCFG, 8'hb0);
    chk({4'h0, sels}, 8'h0e);
    wr(`DLCT_OFF_CLKCFG, 8'h0c);
    wr(`DLCT_OFF_IRQCFG, 8'h03);
    for (int m = 0; m < 3; m++) begin
      wr(`DLCT_OFF_T0LO, lo[m]);
      wr(`DLCT_OFF_T0HI, hi[m]);
      wr(`DLCT_OFF_MODECFG, 8'(m));
      wr(`DLCT_OFF_RUNSTAT, 8'h10);
      wait (firstTimerIrq === 1'b1);
      @(posedge clk);
      wr(`DLCT_OFF_RUNSTAT, 8'h20);
      rc(`DLCT_OFF_T0HI, ex[m]);
      firstVectorTaken <= 1'b1;
      @(posedge clk);
      firstVectorTaken <= 1'b0;
      @(posedge clk);
      chk({7'h0, firstTimerIrq}, 8'h00);
    end
    wr(`DLCT_OFF_IRQCFG, 8'h04);
    wr(`DLCT_OFF_RUNSTAT, 8'h20);
    chk({7'h0, firstTimerIrq}, 8'h00);
    rc(`DLCT_OFF_RUNSTAT, 8'h20);
    wr(`DLCT_OFF_T0LO, 8'h00);
    wr(`DLCT_OFF_T1LO, 8'h00);
    wr(`DLCT_OFF_MODECFG, 8'h99);
    wr(`DLCT_OFF_RUNSTAT, 8'h50);
    repeat (20) @(posedge clk);
    rc(`DLCT_OFF_T0LO, 8'h00);
    rc(`DLCT_OFF_T1LO, 8'h00);
    ext_irq_input_a <= 1'b1;
    ext_irq_input_b <= 1'b0;
    repeat (20) @(posedge clk);
    wr(`DLCT_OFF_RUNSTAT, 8'h00);
    bus(`DLCT_OFF_T0LO, 1'b0, 8'h00);
    chk({7'h0, q != 8'h00}, 8'h01);
    bus(`DLCT_OFF_T1LO, 1'b0, 8'h00);
    chk({7'h0, q != 8'h00}, 8'h01);
    wr(`DLCT_OFF_T0LO, 8'h00);
    wr(`DLCT_OFF_MODECFG, 8'h05);
    wr(`DLCT_OFF_RUNSTAT, 8'h10);
    u_pins.pulse(3, 1'b0);
    wr(`DLCT_OFF_RUNSTAT, 8'h00);
    rc(`DLCT_OFF_T0LO, 8'h03);
    wr(`DLCT_OFF_T1LO, 8'h00);
    wr(`DLCT_OFF_MODECFG, 8'h50);
    wr(`DLCT_OFF_RUNSTAT, 8'h40);
    u_pins.pulse(3, 1'b1);
    wr(`DLCT_OFF_RUNSTAT, 8'h00);
    rc(`DLCT_OFF_T1LO, 8'h03);
    wr(`DLCT_OFF_MODECFG, 8'h01);
    for (int s = 0; s < 4; s++) begin
      wr(`DLCT_OFF_CLKCFG, 8'(s));
      wr(`DLCT_OFF_T0LO, 8'h00);
      wr(`DLCT_OFF_RUNSTAT, 8'h10);
      repeat (93) @(posedge clk);
      wr(`DLCT_OFF_RUNSTAT, 8'h00);
      bus(`DLCT_OFF_T0LO, 1'b0, 8'h00);
      chk({7'h0, q + 8'd1 >= pe[s] && q <= pe[s] + 8'd1}, 8'h01);
    end
    wr(`DLCT_OFF_CLKCFG, 8'h04);
    wr(`DLCT_OFF_IRQCFG, 8'h02);
    wr(`DLCT_OFF_T0LO, 8'h00);
    wr(`DLCT_OFF_T0HI, 8'h00);
    wr(`DLCT_OFF_T1LO, 8'hf0);
    wr(`DLCT_OFF_T1HI, 8'hff);
    wr(`DLCT_OFF_MODECFG, 8'h53);
    wait (secondTimerOvf === 1'b1);
    @(posedge clk);
    chk({7'h0, secondTimerIrq}, 8'h00);
    wr(`DLCT_OFF_RUNSTAT, 8'h40);
    wait (secondTimerIrq === 1'b1);
    @(posedge clk);
    wr(`DLCT_OFF_RUNSTAT, 8'h80);
    rc(`DLCT_OFF_T0LO, 8'h00);
    secondVectorTaken <= 1'b1;
    @(posedge clk);
    secondVectorTaken <= 1'b0;
    @(posedge clk);
    chk({7'h0, secondTimerIrq}, 8'h00);
    wr(`DLCT_OFF_MODECFG, 8'h73);
    wr(`DLCT_OFF_T1LO, 8'h00);
    repeat (20) @(posedge clk);
    rc(`DLCT_OFF_T1LO, 8'h00);
    close_out();
  end
endmodule : dlct_timer_tb
`default_nettype wire
